/* src/acc_pkg.sv */
package acc_pkg;

    // ********************************************************
    // Frame bytes and status words
    // ********************************************************
    localparam logic [7:0] ACC_CLA_OK = 8'h00;
    localparam logic [7:0] ACC_INS_SELECT = 8'hA4;
    localparam logic [7:0] ACC_INS_READ = 8'hB0;
    localparam logic [7:0] ACC_INS_WRITE = 8'hD6;
    localparam logic [15:0] ACC_SW_OK = 16'h9000;
    localparam logic [15:0] ACC_SW_CLA = 16'h6E00;
    localparam logic [15:0] ACC_SW_INS = 16'h6D00;
    localparam logic [15:0] ACC_SW_PARAM = 16'h6A86;
    localparam logic [15:0] ACC_SW_LEN = 16'h6700;

    // ********************************************************
    // P1 field layout and transfer modes
    // ********************************************************
    localparam int ACC_P1_ADDR_HI_BIT = 7;
    localparam int ACC_P1_MODE_LSB = 4;
    localparam logic [2:0] ACC_MODE_PLAIN = 3'h0;
    localparam logic [2:0] ACC_MODE_PRIV = 3'h2;
    localparam logic [2:0] ACC_MODE_FAM = 3'h3;
    localparam logic [3:0] ACC_CRYPT_ALIGN_MASK = 4'hF;
    localparam logic [7:0] ACC_CRYPT_OVERHEAD = 8'h20;

    // ********************************************************
    // AFI and frame wait time
    // ********************************************************
    localparam logic [7:0] ACC_AFI_ANY = 8'h00;
    localparam logic [3:0] ACC_FWI_MAX = 4'hE;
    localparam int ACC_FWT_BASE_CARRIER = 256 * 16;
    localparam int ACC_PUPI_BYTES = 4;

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic [7:0] ACC_RST_BYTE = 8'h00;

    typedef enum logic [2:0] {
        ACC_ST_HDR,
        ACC_ST_DATA,
        ACC_ST_TAIL,
        ACC_ST_RESP,
        ACC_ST_SW1,
        ACC_ST_SW2
    } acc_state_t;

endpackage : acc_pkg

/* src/acc_link_if.sv */
interface acc_link_if;
    // Command byte stream, reader to tag
    logic cmd_valid;
    logic [7:0] cmd_byte;
    logic cmd_last;
    logic cmd_ready;
    // Response byte stream, tag to reader
    logic rsp_valid;
    logic [7:0] rsp_byte;
    logic rsp_last;
    logic rsp_ready;

    modport tag (
        input cmd_valid, cmd_byte, cmd_last, rsp_ready,
        output cmd_ready, rsp_valid, rsp_byte, rsp_last
    );
    modport reader (
        output cmd_valid, cmd_byte, cmd_last, rsp_ready,
        input cmd_ready, rsp_valid, rsp_byte, rsp_last
    );
endinterface : acc_link_if

/* src/acc_afi_match.sv */
// Card request family filter, pure combinational
module acc_afi_match
    import acc_pkg::*;
(
    input wire logic [7:0] req_afi,
    input wire logic [7:0] stored_afi,
    output logic hit
);
    always_comb begin
        if (req_afi == ACC_AFI_ANY) begin
            hit = 1'b1;
        end else if (req_afi[3:0] == 4'h0) begin
            hit = (req_afi[7:4] == stored_afi[7:4]);
        end else if (req_afi[7:4] == 4'h0) begin
            hit = (req_afi[3:0] == stored_afi[3:0]);
        end else begin
            hit = (req_afi == stored_afi);
        end
    end
endmodule : acc_afi_match

/* src/acc_tag_end.sv */
module acc_tag_end
    import acc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    acc_link_if.tag link,
    input wire logic [7:0] stored_afi,
    input wire logic [63:0] stored_identifier_area,
    input wire logic [3:0] fwi_cfg,
    input wire logic [7:0] card_req_afi,
    output logic card_req_hit,
    output logic [31:0] pupi,
    output logic [3:0] fwi,
    output logic mem_req,
    output logic mem_write,
    output logic [14:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    output logic [2:0] xfer_mode,
    output logic payload_strobe
);

    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        acc_state_t st;
        logic [2:0] hcnt;
        logic [7:0] cla;
        logic [7:0] ins;
        logic [7:0] p1;
        logic [7:0] p2;
        logic [7:0] lc;
        logic [7:0] le;
        logic has_lc;
        logic has_le;
        logic [7:0] dcnt;
        logic [15:0] sw;
        logic [14:0] addr;
        logic mem_req;
        logic mem_write;
        logic [7:0] wdata;
        logic pay;
        logic rv;
        logic [7:0] rb;
        logic rl;
        logic rdy;
        logic hit;
        logic [31:0] pupi;
        logic [3:0] fwi;
    } acc_tag_state_t;

    acc_tag_state_t s_q;
    acc_tag_state_t s_d;
    logic afi_hit;
    logic [2:0] mode;
    logic crypt;
    logic [15:0] chk_sw;
    logic [7:0] dlen;

    acc_afi_match u_afi (
        .req_afi(card_req_afi),
        .stored_afi(stored_afi),
        .hit(afi_hit)
    );

    // ********************************************************
    // Header checks, ordered by priority
    // ********************************************************
    assign mode = s_q.p1[ACC_P1_MODE_LSB +: 3];
    assign crypt = (mode == ACC_MODE_PRIV) || (mode == ACC_MODE_FAM);
    // Encrypted lengths include IV and MAC around the payload
    assign dlen = s_q.has_lc ? s_q.lc : (s_q.has_le ? s_q.le : 8'h00);
    always_comb begin
        chk_sw = ACC_SW_OK;
        if (s_q.cla != ACC_CLA_OK) begin
            chk_sw = ACC_SW_CLA;
        end else if (s_q.ins == ACC_INS_SELECT) begin
            chk_sw = ACC_SW_OK;
        end else if (s_q.ins != ACC_INS_READ &&
                     s_q.ins != ACC_INS_WRITE) begin
            chk_sw = ACC_SW_INS;
        end else if (s_q.p1[ACC_P1_ADDR_HI_BIT]) begin
            chk_sw = ACC_SW_PARAM;
        end else if (!crypt && mode != ACC_MODE_PLAIN) begin
            chk_sw = ACC_SW_PARAM;
        end else if (crypt &&
                     (s_q.p2[3:0] & ACC_CRYPT_ALIGN_MASK) != 4'h0) begin
            chk_sw = ACC_SW_PARAM;
        end else if (crypt && ((dlen[3:0] != 4'h0) ||
                     dlen < ACC_CRYPT_OVERHEAD)) begin
            chk_sw = ACC_SW_LEN;
        end
    end

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb begin
        s_d = s_q;
        s_d.mem_req = 1'b0;
        s_d.pay = 1'b0;
        s_d.hit = afi_hit;
        // Low four bytes of the identifier area
        s_d.pupi = stored_identifier_area[ACC_PUPI_BYTES*8-1:0];
        // Exponent of the wait time: base unit times 2^fwi
        s_d.fwi = fwi_cfg;
        // Out-of-range FWI clamped to the largest legal value
        if (fwi_cfg > ACC_FWI_MAX) begin
            s_d.fwi = ACC_FWI_MAX;
        end
        // Marker dropped with valid so no stray last is left standing
        if (s_q.rv && link.rsp_ready) begin
            s_d.rv = 1'b0;
            s_d.rl = 1'b0;
        end
        case (s_q.st)
            ACC_ST_HDR: begin
                if (link.cmd_valid && s_q.rdy) begin
                    case (s_q.hcnt)
                        3'h0: s_d.cla = link.cmd_byte;
                        3'h1: s_d.ins = link.cmd_byte;
                        3'h2: s_d.p1 = link.cmd_byte;
                        3'h3: s_d.p2 = link.cmd_byte;
                        default: s_d.lc = link.cmd_byte;
                    endcase
                    s_d.hcnt = s_q.hcnt + 3'h1;
                    if (link.cmd_last) begin
                        // Fifth byte last means it was Le
                        s_d.has_le = (s_q.hcnt == 3'h4);
                        s_d.le = link.cmd_byte;
                        s_d.has_lc = 1'b0;
                        s_d.st = ACC_ST_TAIL;
                    end else if (s_q.hcnt == 3'h4) begin
                        s_d.has_lc = 1'b1;
                        // Le of an earlier frame must not leak in
                        s_d.has_le = 1'b0;
                        s_d.dcnt = 8'h00;
                        s_d.st = ACC_ST_DATA;
                    end
                end
            end
            ACC_ST_DATA: begin
                // Payload only counted here; no store behind this end
                if (link.cmd_valid && s_q.rdy) begin
                    s_d.dcnt = s_q.dcnt + 8'h01;
                    if (s_q.dcnt == s_q.lc) begin
                        s_d.has_le = 1'b1;
                        s_d.le = link.cmd_byte;
                    end
                    if (link.cmd_last) begin
                        s_d.st = ACC_ST_TAIL;
                    end
                end
            end
            ACC_ST_TAIL: begin
                s_d.sw = chk_sw;
                s_d.addr = {s_q.p1[6:0], s_q.p2};
                s_d.dcnt = 8'h00;
                if (chk_sw == ACC_SW_OK && s_q.ins == ACC_INS_READ &&
                    s_q.has_le) begin
                    s_d.st = ACC_ST_RESP;
                end else begin
                    s_d.st = ACC_ST_SW1;
                end
                if (chk_sw == ACC_SW_OK && s_q.ins == ACC_INS_WRITE) begin
                    s_d.mem_req = 1'b1;
                    s_d.mem_write = 1'b1;
                    s_d.pay = !crypt;
                end
            end
            ACC_ST_RESP: begin
                if (!s_q.rv || link.rsp_ready) begin
                    s_d.mem_req = 1'b1;
                    s_d.mem_write = 1'b0;
                    s_d.addr = s_q.addr + 15'h0001;
                    s_d.rv = 1'b1;
                    s_d.rb = mem_rdata;
                    s_d.rl = 1'b0;
                    s_d.dcnt = s_q.dcnt + 8'h01;
                    if (s_q.dcnt + 8'h01 == s_q.le) begin
                        s_d.st = ACC_ST_SW1;
                    end
                end
            end
            ACC_ST_SW1: begin
                if (!s_q.rv || link.rsp_ready) begin
                    s_d.rv = 1'b1;
                    s_d.rb = s_q.sw[15:8];
                    s_d.rl = 1'b0;
                    s_d.st = ACC_ST_SW2;
                end
            end
            ACC_ST_SW2: begin
                if (!s_q.rv || link.rsp_ready) begin
                    s_d.rv = 1'b1;
                    s_d.rb = s_q.sw[7:0];
                    s_d.rl = 1'b1;
                    s_d.hcnt = 3'h0;
                    s_d.st = ACC_ST_HDR;
                end
            end
            default: s_d.st = ACC_ST_HDR;
        endcase
        // Registered ready: low whenever a response byte is pending
        s_d.rdy = ((s_d.st == ACC_ST_HDR) || (s_d.st == ACC_ST_DATA)) &&
                  !s_d.rv;
    end

    // ********************************************************
    // Registers
    // ********************************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Command bytes taken only while parsing, not while answering
    assign link.cmd_ready = s_q.rdy;
    assign link.rsp_valid = s_q.rv;
    assign link.rsp_byte = s_q.rb;
    assign link.rsp_last = s_q.rl;
    assign card_req_hit = s_q.hit;
    assign pupi = s_q.pupi;
    assign fwi = s_q.fwi;
    assign mem_req = s_q.mem_req;
    assign mem_write = s_q.mem_write;
    assign mem_addr = s_q.addr;
    assign mem_wdata = s_q.wdata;
    assign xfer_mode = s_q.p1[ACC_P1_MODE_LSB +: 3];
    assign payload_strobe = s_q.pay;

endmodule : acc_tag_end

/* src/acc_reader_end.sv */
// Reader end: serialises a command, collects response status
module acc_reader_end
    import acc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    acc_link_if.reader link,
    input wire logic start,
    input wire logic [31:0] hdr,
    input wire logic [7:0] le_byte,
    input wire logic send_le,
    output logic busy,
    output logic [15:0] status,
    output logic done
);
    typedef struct packed {
        logic busy;
        logic [2:0] idx;
        logic v;
        logic [7:0] b;
        logic l;
        logic [15:0] sw;
        logic [15:0] status;
        logic done;
    } acc_rd_state_t;

    acc_rd_state_t s_q;
    acc_rd_state_t s_d;

    // ********************************************************
    // Command out, response in
    // ********************************************************
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (!s_q.busy && start) begin
            s_d.busy = 1'b1;
            s_d.idx = 3'h0;
            s_d.v = 1'b1;
            s_d.b = hdr[31:24];
            s_d.l = 1'b0;
        end else if (s_q.v && link.cmd_ready) begin
            s_d.idx = s_q.idx + 3'h1;
            // After P2 only Le may follow; no Lc or data is sent
            s_d.v = (s_q.idx < 3'h3) || (s_q.idx == 3'h3 && send_le);
            case (s_q.idx)
                3'h0: s_d.b = hdr[23:16];
                3'h1: s_d.b = hdr[15:8];
                3'h2: s_d.b = hdr[7:0];
                default: s_d.b = le_byte;
            endcase
            s_d.l = (s_q.idx == 3'h2 && !send_le) || s_q.idx == 3'h3;
        end
        if (link.rsp_valid) begin
            s_d.sw = {s_q.sw[7:0], link.rsp_byte};
            if (link.rsp_last) begin
                s_d.status = {s_q.sw[7:0], link.rsp_byte};
                s_d.done = 1'b1;
                s_d.busy = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign link.cmd_valid = s_q.v;
    assign link.cmd_byte = s_q.b;
    assign link.cmd_last = s_q.l;
    assign link.rsp_ready = 1'b1;
    assign busy = s_q.busy;
    assign status = s_q.status;
    assign done = s_q.done;

endmodule : acc_reader_end

/* testbench/acc_link_chk.sv */
// ****************************************
// Link checker: watches both frame streams
// ****************************************
module acc_link_chk
    import acc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic cmd_last,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_byte,
    input wire logic rsp_last,
    input wire logic rsp_ready
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [2:0] idx_q;
    logic [2:0] nb_q;
    logic [7:0] hb_q [0:4];
    logic take;
    logic sw_end;
    logic rdwr;
    logic enc;

    // Frame decode of the last command seen
    assign take = cmd_valid && cmd_ready;
    assign sw_end = rsp_valid && rsp_ready && rsp_last;
    assign rdwr = hb_q[0] == ACC_CLA_OK && !hb_q[2][7]
        && (hb_q[1] == ACC_INS_READ || hb_q[1] == ACC_INS_WRITE);
    assign enc = hb_q[2][6:4] == ACC_MODE_PRIV
        || hb_q[2][6:4] == ACC_MODE_FAM;

    // Header capture; only the first five bytes matter here
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            idx_q <= 3'h0;
            nb_q <= 3'h0;
        end else if (take) begin
            if (idx_q < 3'h5) begin
                hb_q[idx_q] <= cmd_byte;
            end
            idx_q <= cmd_last ? 3'h0 : idx_q + 3'h1;
            nb_q <= cmd_last ? idx_q : nb_q;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_answer_delay: assert property (
        take && cmd_last |-> ##[2:4] rsp_valid)
        else $error("no answer after command");
    a_busy_refuse: assert property (rsp_valid |-> !cmd_ready)
        else $error("command taken while answering");
    a_last_valid: assert property (rsp_last |-> rsp_valid)
        else $error("last marker without valid");
    a_sw_pair: assert property (sw_end |-> $past(rsp_valid))
        else $error("status word not two bytes");
    a_cla_code: assert property (
        sw_end && hb_q[0] != ACC_CLA_OK
        |-> {$past(rsp_byte), rsp_byte} == ACC_SW_CLA)
        else $error("bad class status wrong");
    a_err_nodata: assert property (
        rsp_valid && !rsp_last && !$past(rsp_valid)
        && hb_q[0] != ACC_CLA_OK |=> rsp_last)
        else $error("error answer carries data");
    a_p1_top: assert property (
        sw_end && hb_q[0] == ACC_CLA_OK
        && hb_q[1] == ACC_INS_READ && hb_q[2][7]
        |-> {$past(rsp_byte), rsp_byte} == ACC_SW_PARAM)
        else $error("P1 top bit not refused");
    a_mode_bad: assert property (
        sw_end && rdwr && !enc
        && hb_q[2][6:4] != ACC_MODE_PLAIN
        |-> {$past(rsp_byte), rsp_byte} == ACC_SW_PARAM)
        else $error("reserved mode not refused");
    a_enc_align: assert property (
        sw_end && rdwr && enc
        && (hb_q[3][3:0] & ACC_CRYPT_ALIGN_MASK) != 4'h0
        |-> {$past(rsp_byte), rsp_byte} == ACC_SW_PARAM)
        else $error("misaligned address not refused");
    a_enc_len: assert property (
        sw_end && rdwr && enc && hb_q[3][3:0] == 4'h0
        && nb_q == 3'h4 && hb_q[4][3:0] != 4'h0
        |-> {$past(rsp_byte), rsp_byte} == ACC_SW_LEN)
        else $error("bad encrypted length not refused");

    c_cla_err: cover property (sw_end && hb_q[0] != ACC_CLA_OK);
    c_enc_end: cover property (sw_end && rdwr && enc);
    c_cmd_end: cover property (take && cmd_last);
endmodule : acc_link_chk

/* testbench/test_apdu_command_checker.sv */
module test_apdu_command_checker
    import acc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic ref_clk;
    logic rst_n;
    logic start;
    logic [31:0] hdr;
    logic [7:0] le_byte;
    logic send_le;
    logic [15:0] status;
    logic done;
    logic [7:0] stored_afi;
    logic [63:0] stored_identifier_area;
    logic [3:0] fwi_cfg;
    logic [7:0] card_req_afi;
    logic card_req_hit;
    logic [31:0] pupi;
    logic [3:0] fwi;
    logic [2:0] xfer_mode;
    logic busy;
    logic mem_req;
    logic mem_write;
    logic [14:0] mem_addr;
    logic pay_strobe;
    int req_count;
    int pay_count;
    int fail_count;
    int check_count;

    acc_link_if link();

    acc_tag_end acc_tag_end_inst (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .link(link),
        .stored_afi(stored_afi),
        .stored_identifier_area(stored_identifier_area),
        .fwi_cfg(fwi_cfg),
        .card_req_afi(card_req_afi),
        .card_req_hit(card_req_hit),
        .pupi(pupi),
        .fwi(fwi),
        .mem_req(mem_req),
        .mem_write(mem_write),
        .mem_addr(mem_addr),
        .mem_wdata(),
        .mem_rdata(8'h5A),
        .xfer_mode(xfer_mode),
        .payload_strobe(pay_strobe)
    );

    acc_reader_end acc_reader_end_inst (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .link(link),
        .start(start),
        .hdr(hdr),
        .le_byte(le_byte),
        .send_le(send_le),
        .busy(busy),
        .status(status),
        .done(done)
    );

    acc_link_chk acc_link_chk_inst (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .cmd_valid(link.cmd_valid),
        .cmd_byte(link.cmd_byte),
        .cmd_last(link.cmd_last),
        .cmd_ready(link.cmd_ready),
        .rsp_valid(link.rsp_valid),
        .rsp_byte(link.rsp_byte),
        .rsp_last(link.rsp_last),
        .rsp_ready(link.rsp_ready)
    );

    // ****************************************
    // Shared helpers
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Memory request and payload strobe pulses, counted edge by edge
    always @(posedge ref_clk) begin
        if (mem_req === 1'h1) begin
            req_count <= req_count + 1;
        end
        if (pay_strobe === 1'h1) begin
            pay_count <= pay_count + 1;
        end
    end

    // One command through the reader end, status compared at done
    task automatic run(input logic [31:0] h, input logic sl,
                       input logic [7:0] le, input logic [15:0] exp);
        int n;
        @(posedge ref_clk);
        hdr <= h;
        send_le <= sl;
        le_byte <= le;
        start <= 1'h1;
        @(posedge ref_clk);
        start <= 1'h0;
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (done !== 1'h1 && n < 300);
        // A missing answer must not pass on a stale status
        chk({31'h0, done}, 32'h1);
        chk({31'h0, busy}, 32'h0);
        chk({16'h0, status}, {16'h0, exp});
    endtask : run

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_header;
        run(32'h01B0_0000, 1'h1, 8'h10, ACC_SW_CLA);
        run(32'hFFCA_8000, 1'h0, 8'h00, ACC_SW_CLA);
        run(32'h00CA_0000, 1'h0, 8'h00, ACC_SW_INS);
        run(32'h00A4_0400, 1'h0, 8'h00, ACC_SW_OK);
        run(32'h00B0_8000, 1'h1, 8'h10, ACC_SW_PARAM);
        run(32'h00D6_F300, 1'h1, 8'h10, ACC_SW_PARAM);
    endtask : t_header

    // Every mode code; reserved ones must be refused
    task automatic t_modes;
        logic [2:0] m;
        logic ok;
        for (int i = 0; i < 8; i++) begin
            m = i[2:0];
            ok = m == ACC_MODE_PLAIN || m == ACC_MODE_PRIV
                || m == ACC_MODE_FAM;
            run({16'h00B0, 1'h0, m, 12'h000}, 1'h1, 8'h20,
                ok ? ACC_SW_OK : ACC_SW_PARAM);
            if (ok) begin
                chk({29'h0, xfer_mode}, {29'h0, m});
            end
        end
    endtask : t_modes

    // Address grain and length grain per mode
    task automatic t_align_len;
        run(32'h00B0_2008, 1'h1, 8'h20, ACC_SW_PARAM);
        run(32'h00B0_0007, 1'h1, 8'h05, ACC_SW_OK);
        run(32'h00B0_2010, 1'h1, 8'h10, ACC_SW_LEN);
        run(32'h00B0_3020, 1'h1, 8'h28, ACC_SW_LEN);
        run(32'h00B0_3020, 1'h1, 8'h30, ACC_SW_OK);
    endtask : t_align_len

    // One family filter case: stored, request, expected hit
    task automatic afi_case(input logic [7:0] sa, input logic [7:0] ra,
                            input logic e);
        @(posedge ref_clk);
        stored_afi <= sa;
        card_req_afi <= ra;
        repeat (2) @(posedge ref_clk);
        #1;
        chk({31'h0, card_req_hit}, {31'h0, e});
    endtask : afi_case

    // Family filter: wildcard, nibble matches and full match
    task automatic t_afi;
        afi_case(8'hB4, 8'h00, 1'h1);
        afi_case(8'hB4, 8'hA0, 1'h0);
        afi_case(8'hB4, 8'hB0, 1'h1);
        afi_case(8'hB4, 8'h04, 1'h1);
        afi_case(8'hB4, 8'h05, 1'h0);
        afi_case(8'hB4, 8'hB4, 1'h1);
        afi_case(8'hB4, 8'hB5, 1'h0);
        afi_case(8'h5A, 8'h4A, 1'h0);
    endtask : t_afi

    // Identifier slice and wait-time index clamp
    task automatic t_ident;
        @(posedge ref_clk);
        stored_identifier_area <= 64'h0123_4567_89AB_CDEF;
        fwi_cfg <= 4'hF;
        repeat (3) @(posedge ref_clk);
        #1;
        chk(pupi, 32'h89AB_CDEF);
        chk({28'h0, fwi}, {28'h0, ACC_FWI_MAX});
        @(posedge ref_clk);
        fwi_cfg <= 4'h3;
        repeat (3) @(posedge ref_clk);
        #1;
        chk({28'h0, fwi}, 32'h3);
    endtask : t_ident

    // Memory side: read burst length, write address and strobe
    task automatic t_mem;
        int r0;
        int p0;
        r0 = req_count;
        run(32'h00B0_0123, 1'h1, 8'h03, ACC_SW_OK);
        chk(req_count - r0, 32'h3);
        r0 = req_count;
        p0 = pay_count;
        run(32'h00D6_0123, 1'h0, 8'h00, ACC_SW_OK);
        chk({17'h0, mem_addr}, 32'h0123);
        chk({31'h0, mem_write}, 32'h1);
        chk(req_count - r0, 32'h1);
        chk(pay_count - p0, 32'h1);
        r0 = req_count;
        p0 = pay_count;
        run(32'h00D6_2020, 1'h1, 8'h20, ACC_SW_OK);
        chk(req_count - r0, 32'h1);
        chk(pay_count - p0, 32'h0);
        r0 = req_count;
        run(32'h01D6_0000, 1'h0, 8'h00, ACC_SW_CLA);
        chk(req_count - r0, 32'h0);
    endtask : t_mem

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // Free-running clock
    initial begin
        ref_clk = 1'h0;
        forever #2 ref_clk = ~ref_clk;
    end

    // Some 23 commands of under 60 cycles each; over ten times that is ample
    initial begin
        #80000;
        fail_count++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        fail_count = 0;
        check_count = 0;
        rst_n = 1'h0;
        start = 1'h0;
        hdr = 32'h0;
        le_byte = 8'h00;
        send_le = 1'h0;
        stored_afi = 8'h00;
        stored_identifier_area = 64'h0;
        fwi_cfg = 4'h0;
        card_req_afi = 8'h00;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'h1;
        t_header();
        t_modes();
        t_align_len();
        t_afi();
        t_ident();
        t_mem();
        tally_and_finish();
    end
endmodule : test_apdu_command_checker
